//--- rtl/pic_top.sv
// priority interrupt controller core with register file and arbiter
`timescale 1ns/1ps
module pic_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_nmi_pin,
  input wire logic i_ext_req0_n,
  input wire logic i_ext_req1_n,
  input wire logic i_wdog_ovf,
  input wire logic i_wdog_timer_en,
  input wire logic i_wdog_nmi_select,
  input wire logic [18:0] i_int_req,
  input wire logic [18:0] i_int_en,
  input wire logic [2:0] i_mask_level,
  input wire logic i_max_mode,
  input wire logic i_ack,
  input wire logic [4:0] i_ack_idx,
  output logic o_cpu_req,
  output logic o_dtc_req,
  output logic [3:0] o_req_level,
  output logic [4:0] o_req_idx,
  output logic [7:0] o_vec_addr,
  output logic o_clr_trace,
  output logic o_mask_load,
  output logic [2:0] o_mask_value,
  output logic [18:0] o_int_clear
);
  typedef struct packed {
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic [7:0] prio_c;
    logic [7:0] prio_d;
    logic [7:0] dte_a;
    logic [7:0] dte_b;
    logic [7:0] dte_c;
    logic [7:0] dte_d;
    logic [7:0] port1_ctrl_reg;
    logic [7:0] rdata;
    logic [21:0] pend_s1;
    logic [3:0] lvl_s1;
    logic [4:0] idx_s1;
    logic any_s1;
    logic cpu_req;
    logic dtc_req;
    logic [3:0] req_level;
    logic [4:0] req_idx;
    logic [7:0] vec;
    logic clr_trace;
    logic mask_load;
    logic [2:0] mask_value;
    logic [18:0] int_clear;
  } pic_st_t;
  pic_st_t s_q;
  pic_st_t s_d;

  logic nmi_pend;
  logic ext1_pend;
  logic ext0_level;
  logic [21:0] pend;
  logic [3:0] src_lvl [22];
  logic [21:0] to_dtc;
  logic [7:0] vec_w;
  logic ack_nmi;
  logic ack_ext1;
  logic ack_valid;
  logic ack_by_cpu;

  // module number of each internal source, 0..5
  function automatic logic [2:0] mod_of(input logic [4:0] idx);
    if (idx < 5'h07) begin
      mod_of = 3'h0;
    end else if (idx < 5'h0B) begin
      mod_of = 3'h1;
    end else if (idx < 5'h0F) begin
      mod_of = 3'h2;
    end else if (idx < 5'h12) begin
      mod_of = 3'h3;
    end else if (idx < 5'h15) begin
      mod_of = 3'h4;
    end else begin
      mod_of = 3'h5;
    end
  endfunction

  // module level from the priority registers: even modules own the upper field
  function automatic logic [2:0] mod_level(input logic [2:0] m, input logic [7:0] pb, input logic [7:0] pc,
      input logic [7:0] pd);
    logic [7:0] r;
    unique case (m[2:1])
      2'h0: r = pb;
      2'h1: r = pc;
      default: r = pd;
    endcase
    if (m[0]) begin
      mod_level = r[pic_pkg::LO_FIELD +: pic_pkg::LVL_W];
    end else begin
      mod_level = r[pic_pkg::HI_FIELD +: pic_pkg::LVL_W];
    end
  endfunction

  // sources never served by transfer unit
  function automatic logic cpu_only(input logic [4:0] idx);
    unique case (idx)
      5'h00, 5'h06, 5'h0A, 5'h0E, 5'h11, 5'h12: cpu_only = 1'b1;
      default: cpu_only = 1'b0;
    endcase
  endfunction

  // register number of a bus address, shared by the write and read paths
  function automatic logic [3:0] reg_num(input logic [15:0] a);
    unique case (a)
      pic_pkg::ADDR_PRIO_A: reg_num = 4'h0;
      pic_pkg::ADDR_PRIO_B: reg_num = 4'h1;
      pic_pkg::ADDR_PRIO_C: reg_num = 4'h2;
      pic_pkg::ADDR_PRIO_D: reg_num = 4'h3;
      pic_pkg::ADDR_DTE_A: reg_num = 4'h4;
      pic_pkg::ADDR_DTE_B: reg_num = 4'h5;
      pic_pkg::ADDR_DTE_C: reg_num = 4'h6;
      pic_pkg::ADDR_DTE_D: reg_num = 4'h7;
      pic_pkg::ADDR_PORT1_CTRL_REG: reg_num = 4'h8;
      default: reg_num = 4'hF;
    endcase
  endfunction

  assign ack_nmi = i_ack & (i_ack_idx == pic_pkg::SRC_NMI);
  assign ack_ext1 = i_ack & (i_ack_idx == pic_pkg::SRC_EXT1);

  // acks outside the source table are dropped,
  // so a bad index never reaches the level or route tables
  assign ack_valid = i_ack & (i_ack_idx < 5'(pic_pkg::NUM_SRC));
  // only a cpu sequence changes trace and mask
  assign ack_by_cpu = ack_valid && (cpu_only(i_ack_idx) || !to_dtc[i_ack_idx]);

  pic_edge_latch u_nmi (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_pin(i_nmi_pin),
    .i_rise(s_q.port1_ctrl_reg[pic_pkg::NMI_EDGE_BIT]),
    .i_enable(1'b1),
    .i_extra(i_wdog_ovf & i_wdog_timer_en & i_wdog_nmi_select),
    .i_clear(ack_nmi),
    .o_pending(nmi_pend)
  );

  pic_edge_latch u_ext1 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_req1_n),
    .i_rise(1'b0),
    .i_enable(s_q.port1_ctrl_reg[pic_pkg::EXT1_EN_BIT]),
    .i_extra(1'b0),
    .i_clear(ack_ext1),
    .o_pending(ext1_pend)
  );

  // level request, agent holds it low
  assign ext0_level = (~i_ext_req0_n & s_q.port1_ctrl_reg[pic_pkg::EXT0_EN_BIT]) |
                      (i_wdog_ovf & i_wdog_timer_en & ~i_wdog_nmi_select);

  assign pend = {i_int_req & i_int_en, ext1_pend, ext0_level, nmi_pend};

  always_comb begin
    src_lvl[0] = pic_pkg::NMI_LEVEL;
    src_lvl[1] = {1'b0, s_q.prio_a[pic_pkg::HI_FIELD +: pic_pkg::LVL_W]};
    src_lvl[2] = {1'b0, s_q.prio_a[pic_pkg::LO_FIELD +: pic_pkg::LVL_W]};
    for (int i = 3; i < pic_pkg::NUM_SRC; i++) begin
      src_lvl[i] = {1'b0, mod_level(mod_of(5'(i)), s_q.prio_b, s_q.prio_c, s_q.prio_d)};
    end
  end

  // nmi, error and overflows forced to cpu
  always_comb begin
    to_dtc = '0;
    to_dtc[1] = s_q.dte_a[pic_pkg::EXT0_DTE_BIT];
    to_dtc[2] = s_q.dte_a[pic_pkg::EXT1_DTE_BIT];
    to_dtc[5:3] = s_q.dte_b[2:0];
    to_dtc[9:7] = s_q.dte_b[6:4];
    to_dtc[13:11] = s_q.dte_c[2:0];
    to_dtc[16:15] = s_q.dte_c[5:4];
    to_dtc[20:19] = s_q.dte_d[1:0];
    to_dtc[21] = s_q.dte_d[4];
    // no route bit is wired to these sources, yet they are still overruled,
    // so a stray write can never hand them to the transfer unit
    for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
      if (cpu_only(5'(i))) begin
        to_dtc[i] = 1'b0;
      end
    end
  end

  pic_vec_rom u_vec (
    .i_idx(s_q.idx_s1),
    .i_max_mode(i_max_mode),
    .o_vec(vec_w)
  );

  always_comb begin
    s_d = s_q;
    // register writes; reserved bits of the priority registers dropped
    if (i_wr) begin
      unique case (reg_num(i_addr))
        4'h0: s_d.prio_a = i_wdata & pic_pkg::PRIO_MASK;
        4'h1: s_d.prio_b = i_wdata & pic_pkg::PRIO_MASK;
        4'h2: s_d.prio_c = i_wdata & pic_pkg::PRIO_MASK;
        4'h3: s_d.prio_d = i_wdata & pic_pkg::PRIO_MASK;
        4'h4: s_d.dte_a = i_wdata;
        4'h5: s_d.dte_b = i_wdata;
        4'h6: s_d.dte_c = i_wdata;
        4'h7: s_d.dte_d = i_wdata;
        4'h8: s_d.port1_ctrl_reg = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (reg_num(i_addr))
        4'h0: s_d.rdata = s_q.prio_a;
        4'h1: s_d.rdata = s_q.prio_b;
        4'h2: s_d.rdata = s_q.prio_c;
        4'h3: s_d.rdata = s_q.prio_d;
        4'h4: s_d.rdata = s_q.dte_a;
        4'h5: s_d.rdata = s_q.dte_b;
        4'h6: s_d.rdata = s_q.dte_c;
        4'h7: s_d.rdata = s_q.dte_d;
        4'h8: s_d.rdata = s_q.port1_ctrl_reg;
        default: s_d.rdata = 8'h00;
      endcase
    end

    // stage 1: highest level wins, lowest index on ties
    // index order inside a module gives the fixed rank
    s_d.pend_s1 = pend;
    s_d.any_s1 = 1'b0;
    s_d.lvl_s1 = 4'h0;
    s_d.idx_s1 = pic_pkg::SRC_NONE;
    for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
      // level zero never wins, so it is masked from reset on
      if (pend[i] && src_lvl[i] != 4'h0 && (!s_d.any_s1 || src_lvl[i] > s_d.lvl_s1)) begin
        s_d.any_s1 = 1'b1;
        s_d.lvl_s1 = src_lvl[i];
        s_d.idx_s1 = 5'(i);
      end
    end

    // stage 2: strictly above mask; nmi beats any mask
    // registered outputs every cycle
    s_d.cpu_req = 1'b0;
    s_d.dtc_req = 1'b0;
    if (s_q.any_s1 && s_q.pend_s1[s_q.idx_s1] && s_q.lvl_s1 > {1'b0, i_mask_level}) begin
      s_d.cpu_req = ~to_dtc[s_q.idx_s1];
      s_d.dtc_req = to_dtc[s_q.idx_s1];
    end
    s_d.req_level = s_q.lvl_s1;
    s_d.req_idx = s_q.idx_s1;
    s_d.vec = vec_w;

    s_d.clr_trace = 1'b0;
    s_d.mask_load = 1'b0;
    s_d.int_clear = '0;
    // a transfer-unit start is no cpu sequence, so trace and mask are left alone
    if (ack_by_cpu) begin
      s_d.clr_trace = 1'b1;
      s_d.mask_load = 1'b1;
      if (i_ack_idx == pic_pkg::SRC_NMI) begin
        s_d.mask_value = pic_pkg::NMI_MASK;
      end else begin
        s_d.mask_value = src_lvl[i_ack_idx][2:0];
      end
    end
    // either kind of service retires an internal request
    if (ack_valid && i_ack_idx > pic_pkg::SRC_EXT1) begin
      s_d.int_clear[i_ack_idx - 5'h03] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.idx_s1 <= pic_pkg::SRC_NONE;
      s_q.req_idx <= pic_pkg::SRC_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_cpu_req = s_q.cpu_req;
  assign o_dtc_req = s_q.dtc_req;
  assign o_req_level = s_q.req_level;
  assign o_req_idx = s_q.req_idx;
  assign o_vec_addr = s_q.vec;
  assign o_clr_trace = s_q.clr_trace;
  assign o_mask_load = s_q.mask_load;
  assign o_mask_value = s_q.mask_value;
  assign o_int_clear = s_q.int_clear;
endmodule

//--- inc/pic_pkg.sv
// constants for the priority interrupt controller
package pic_pkg;
  localparam int NUM_SRC = 22;
  localparam int NUM_INT = 19;
  localparam int LVL_W = 3;
  localparam int IDX_W = 5;
  localparam logic [3:0] NMI_LEVEL = 4'h8;
  localparam logic [2:0] NMI_MASK = 3'h7;
  localparam logic [15:0] ADDR_PRIO_A = 16'hFFF0;
  localparam logic [15:0] ADDR_PRIO_B = 16'hFFF1;
  localparam logic [15:0] ADDR_PRIO_C = 16'hFFF2;
  localparam logic [15:0] ADDR_PRIO_D = 16'hFFF3;
  localparam logic [15:0] ADDR_DTE_A = 16'hFFF4;
  localparam logic [15:0] ADDR_DTE_B = 16'hFFF5;
  localparam logic [15:0] ADDR_DTE_C = 16'hFFF6;
  localparam logic [15:0] ADDR_DTE_D = 16'hFFF7;
  localparam logic [15:0] ADDR_PORT1_CTRL_REG = 16'hFFFC;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PRIO_MASK = 8'h77;
  localparam int NMI_EDGE_BIT = 4;
  localparam int EXT0_EN_BIT = 5;
  localparam int EXT1_EN_BIT = 6;
  localparam int EXT0_DTE_BIT = 4;
  localparam int EXT1_DTE_BIT = 0;
  localparam int HI_FIELD = 4;
  localparam int LO_FIELD = 0;
  localparam logic [7:0] VEC_NMI_MIN = 8'h16;
  localparam logic [7:0] VEC_NMI_MAX = 8'h2C;
  localparam int EVAL_CYCLES = 2;
  // source index, also the tie order (0 wins)
  localparam logic [4:0] SRC_NMI = 5'h00;
  localparam logic [4:0] SRC_EXT0 = 5'h01;
  localparam logic [4:0] SRC_EXT1 = 5'h02;
  localparam logic [4:0] SRC_NONE = 5'h1F;
endpackage

//--- rtl/pic_edge_latch.sv
// edge detector with sticky request latch
`timescale 1ns/1ps
module pic_edge_latch (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_rise,
  input wire logic i_enable,
  input wire logic i_extra,
  input wire logic i_clear,
  output logic o_pending
);
  typedef struct packed {
    logic prev;
    logic pend;
  } pic_el_st_t;
  pic_el_st_t s_q;
  pic_el_st_t s_d;
  logic edge_hit;
  always_comb begin
    s_d = s_q;
    s_d.prev = i_pin;
    edge_hit = i_enable & (i_rise ? (i_pin & ~s_q.prev) : (~i_pin & s_q.prev));
    // a new edge in the clear cycle still wins
    if (i_clear) begin
      s_d.pend = 1'b0;
    end
    if (edge_hit | i_extra) begin
      s_d.pend = 1'b1;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_pending = s_q.pend;
endmodule

//--- rtl/pic_vec_rom.sv
// vector table address lookup per source
`timescale 1ns/1ps
module pic_vec_rom (
  input wire logic [4:0] i_idx,
  input wire logic i_max_mode,
  output logic [7:0] o_vec
);
  logic [7:0] min_addr;
  always_comb begin
    unique case (i_idx)
      5'h00: min_addr = 8'h16;
      5'h01: min_addr = 8'h40;
      5'h02: min_addr = 8'h42;
      5'h03: min_addr = 8'h48;
      5'h04: min_addr = 8'h4A;
      5'h05: min_addr = 8'h4C;
      5'h06: min_addr = 8'h4E;
      5'h07: min_addr = 8'h50;
      5'h08: min_addr = 8'h52;
      5'h09: min_addr = 8'h54;
      5'h0A: min_addr = 8'h56;
      5'h0B: min_addr = 8'h58;
      5'h0C: min_addr = 8'h5A;
      5'h0D: min_addr = 8'h5C;
      5'h0E: min_addr = 8'h5E;
      5'h0F: min_addr = 8'h60;
      5'h10: min_addr = 8'h62;
      5'h11: min_addr = 8'h64;
      5'h12: min_addr = 8'h68;
      5'h13: min_addr = 8'h6A;
      5'h14: min_addr = 8'h6C;
      5'h15: min_addr = 8'h70;
      default: min_addr = 8'h00;
    endcase
    // maximum mode entries are twice as wide; nmi is the odd one
    if (!i_max_mode) begin
      o_vec = min_addr;
    end else if (i_idx == pic_pkg::SRC_NMI) begin
      o_vec = pic_pkg::VEC_NMI_MAX;
    end else begin
      o_vec = {min_addr[6:0], 1'b0};
    end
  end
endmodule

//--- dv/pic_top_sva.sv
// port assertions for the priority interrupt controller
`timescale 1ns/1ps
module pic_top_sva (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic [2:0] i_mask_level,
  input wire logic i_max_mode,
  input wire logic i_ack,
  input wire logic [4:0] i_ack_idx,
  input wire logic o_cpu_req,
  input wire logic o_dtc_req,
  input wire logic [3:0] o_req_level,
  input wire logic [4:0] o_req_idx,
  input wire logic [7:0] o_vec_addr,
  input wire logic [7:0] o_rdata,
  input wire logic o_clr_trace,
  input wire logic o_mask_load,
  input wire logic [2:0] o_mask_value
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_no_level_zero: assert property ((o_cpu_req || o_dtc_req) |-> o_req_level != 4'h0)
    else $error("level zero request raised");
  // mask must have settled through the pipeline before judging
  a_above_mask: assert property (o_cpu_req && o_req_idx != 5'h00 && i_mask_level == $past(i_mask_level, 1)
    && i_mask_level == $past(i_mask_level, 3) |-> o_req_level > {1'b0, i_mask_level})
    else $error("request at or below mask");
  a_nmi_level_8: assert property (o_cpu_req && o_req_idx == 5'h00 |-> o_req_level == 4'h8)
    else $error("nonmaskable level wrong");
  a_nmi_cpu_only: assert property (o_req_idx == 5'h00 |-> !o_dtc_req)
    else $error("nonmaskable sent to transfer unit");
  a_one_target: assert property (!(o_cpu_req && o_dtc_req))
    else $error("both targets requested");
  a_ack_pulses: assert property (i_ack && !o_dtc_req |=> o_clr_trace && o_mask_load ##1 !o_mask_load)
    else $error("service pulses wrong");
  a_dtc_no_mask: assert property (i_ack && o_dtc_req && i_ack_idx == o_req_idx |=> !o_mask_load && !o_clr_trace)
    else $error("transfer unit start touched mask");
  a_nmi_mask_7: assert property (i_ack && i_ack_idx == 5'h00 |=> o_mask_value == 3'h7)
    else $error("nonmaskable mask not seven");
  a_mask_loads: assert property (i_ack && o_cpu_req && i_ack_idx == o_req_idx && i_ack_idx != 5'h00
    |=> o_mask_value == $past(o_req_level[2:0]))
    else $error("mask not loaded with level");
  a_nmi_vector: assert property (o_cpu_req && o_req_idx == 5'h00 && $stable(i_max_mode)
    |-> o_vec_addr == (i_max_mode ? 8'h2C : 8'h16))
    else $error("nonmaskable vector wrong");
  a_reserved_zero: assert property (i_rd && i_addr[15:2] == 14'h3FFC |=> !o_rdata[7] && !o_rdata[3])
    else $error("reserved bit read one");
  c_dtc: cover property (o_dtc_req);
  c_nmi_ack: cover property (i_ack && i_ack_idx == 5'h00);
  c_timer: cover property (o_cpu_req && o_req_idx == 5'h03);
endmodule

//--- dv/pic_cpu_model.sv
// cpu and transfer unit stand-in: takes requests, keeps the mask level
`timescale 1ns/1ps
module pic_cpu_model #(parameter int LAT = 2) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [4:0] i_idx,
  input wire logic i_mask_load,
  input wire logic [2:0] i_mask_value,
  input wire logic i_set,
  input wire logic [2:0] i_set_val,
  output logic o_ack,
  output logic [4:0] o_ack_idx,
  output logic [2:0] o_mask_level
);
  int cnt;
  logic busy;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      busy <= 1'b0;
      o_ack <= 1'b0;
      o_ack_idx <= 5'h1F;
      o_mask_level <= 3'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_mask_load) o_mask_level <= i_mask_value;
      else if (i_set) o_mask_level <= i_set_val;
      // stale request after service is not taken twice
      if (!i_req || i_idx != o_ack_idx) busy <= 1'b0;
      if (i_req && !busy) begin
        cnt <= cnt + 1;
        if (cnt == LAT) begin
          o_ack <= 1'b1;
          o_ack_idx <= i_idx;
          busy <= 1'b1;
          cnt <= 0;
        end
      end else cnt <= 0;
    end
  end
endmodule

//--- dv/priority_interrupt_controller_bench.sv
// directed bench for the priority interrupt controller
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
  logic i_mclk, i_rst_n, i_wr, i_rd, i_nmi_pin, i_ext_req0_n, i_ext_req1_n, i_wdog_ovf;
  logic i_wdog_timer_en, i_wdog_nmi_select, i_max_mode, i_ack, m_set, clr_seen;
  logic o_cpu_req, o_dtc_req, o_clr_trace, o_mask_load;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_vec_addr, d;
  logic [18:0] i_int_req, i_int_en, o_int_clear;
  logic [2:0] i_mask_level, o_mask_value, m_val;
  logic [4:0] i_ack_idx, o_req_idx;
  logic [3:0] o_req_level;
  int mismatches, compares;
  pic_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_nmi_pin(i_nmi_pin), .i_ext_req0_n(i_ext_req0_n),
    .i_ext_req1_n(i_ext_req1_n), .i_wdog_ovf(i_wdog_ovf), .i_wdog_timer_en(i_wdog_timer_en),
    .i_wdog_nmi_select(i_wdog_nmi_select), .i_int_req(i_int_req), .i_int_en(i_int_en),
    .i_mask_level(i_mask_level), .i_max_mode(i_max_mode), .i_ack(i_ack), .i_ack_idx(i_ack_idx),
    .o_cpu_req(o_cpu_req), .o_dtc_req(o_dtc_req), .o_req_level(o_req_level), .o_req_idx(o_req_idx),
    .o_vec_addr(o_vec_addr), .o_clr_trace(o_clr_trace), .o_mask_load(o_mask_load),
    .o_mask_value(o_mask_value), .o_int_clear(o_int_clear));
  pic_cpu_model u_cpu (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(o_cpu_req | o_dtc_req), .i_idx(o_req_idx),
    .i_mask_load(o_mask_load), .i_mask_value(o_mask_value), .i_set(m_set), .i_set_val(m_val),
    .o_ack(i_ack), .o_ack_idx(i_ack_idx), .o_mask_level(i_mask_level));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n) clr_seen <= 1'b0;
    else if (o_int_clear[0]) clr_seen <= 1'b1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_mclk) begin i_addr <= a; i_wdata <= v; i_wr <= 1'b1; end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_mclk) begin i_addr <= a; i_rd <= 1'b1; end
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic set_mask(input logic [2:0] v);
    @(posedge i_mclk) begin m_set <= 1'b1; m_val <= v; end
    @(posedge i_mclk) m_set <= 1'b0;
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while ((o_cpu_req | o_dtc_req) !== 1'b1) begin
      @(posedge i_mclk);
      #1 n++;
      if (n > 40) begin
        mismatches++;
        finish_test();
      end
    end
  endtask
  task automatic settle(input logic [7:0] mask_exp);
    repeat (8) @(posedge i_mclk);
    #1 chk({5'h00, i_mask_level}, mask_exp);
    chk({7'h00, o_cpu_req | o_dtc_req}, 8'h00);
    @(posedge i_mclk);
  endtask
  task automatic t_regs();
    logic [15:0] al[10] = '{16'hFFF0, 16'hFFF1, 16'hFFF2, 16'hFFF3, 16'hFFF4, 16'hFFF5, 16'hFFF6,
      16'hFFF7, 16'hFFFC, 16'hFFF8};
    foreach (al[k]) begin
      rd(al[k]);
      chk(d, 8'h00);
    end
    wr(16'hFFF3, 8'hFF);
    rd(16'hFFF3);
    chk(d, 8'h77);
    wr(16'hFFF3, 8'h00);
  endtask
  task automatic t_timer();
    wr(16'hFFF1, 8'h30);
    i_int_en <= 19'h0000F;
    i_int_req <= 19'h0000F;
    wait_req();
    chk({3'h0, o_req_idx}, 8'h03);
    chk({4'h0, o_req_level}, 8'h03);
    chk(o_vec_addr, 8'h48);
    chk({7'h00, o_dtc_req}, 8'h00);
    settle(8'h03);
    chk({7'h00, clr_seen}, 8'h01);
    i_int_req <= 19'h00000;
  endtask
  task automatic t_nmi();
    wr(16'hFFFC, 8'h10);
    i_max_mode <= 1'b1;
    i_nmi_pin <= 1'b1;
    wait_req();
    chk({3'h0, o_req_idx}, 8'h00);
    chk({4'h0, o_req_level}, 8'h08);
    chk(o_vec_addr, 8'h2C);
    settle(8'h07);
    i_nmi_pin <= 1'b0;
    settle(8'h07);
    i_max_mode <= 1'b0;
    i_wdog_timer_en <= 1'b1;
    i_wdog_nmi_select <= 1'b1;
    i_wdog_ovf <= 1'b1;
    @(posedge i_mclk) i_wdog_ovf <= 1'b0;
    wait_req();
    chk({3'h0, o_req_idx}, 8'h00);
    chk(o_vec_addr, 8'h16);
    settle(8'h07);
  endtask
  task automatic t_ext();
    set_mask(3'h0);
    wr(16'hFFF0, 8'h55);
    wr(16'hFFF1, 8'h50);
    wr(16'hFFF4, 8'h01);
    wr(16'hFFFC, 8'h60);
    i_int_req <= 19'h00001;
    // agent holds the pin low until accepted
    i_ext_req0_n <= 1'b0;
    wait_req();
    chk({3'h0, o_req_idx}, 8'h01);
    chk({7'h00, o_cpu_req}, 8'h01);
    settle(8'h05);
    i_ext_req0_n <= 1'b1;
    i_int_req <= 19'h00000;
    set_mask(3'h0);
    i_ext_req1_n <= 1'b0;
    wait_req();
    chk({3'h0, o_req_idx}, 8'h02);
    chk({7'h00, o_dtc_req}, 8'h01);
    chk(o_vec_addr, 8'h42);
    // transfer unit service leaves the mask where it was
    settle(8'h00);
    i_ext_req1_n <= 1'b1;
  endtask
  initial begin
    {i_rst_n, i_wr, i_rd, i_nmi_pin, i_wdog_ovf, i_wdog_timer_en, i_wdog_nmi_select, i_max_mode} = 8'h00;
    {m_set, m_val, i_addr, i_wdata, i_int_req, i_int_en} = '0;
    i_ext_req0_n = 1'b1;
    i_ext_req1_n = 1'b1;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_timer();
    t_nmi();
    t_ext();
    finish_test();
  end
endmodule
bind pic_top pic_top_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd),
  .i_mask_level(i_mask_level), .i_max_mode(i_max_mode), .i_ack(i_ack), .i_ack_idx(i_ack_idx),
  .o_cpu_req(o_cpu_req), .o_dtc_req(o_dtc_req), .o_req_level(o_req_level), .o_req_idx(o_req_idx),
  .o_vec_addr(o_vec_addr), .o_rdata(o_rdata), .o_clr_trace(o_clr_trace), .o_mask_load(o_mask_load),
  .o_mask_value(o_mask_value));
